/* rtl/ocs_pkg.sv */
// Constants and types for the one-time-programmable configuration store
// ---------------------------------------------------------------------
// Summary of operation
// - Store holds exactly 40 bits and host programs it through registers.
// - Bits map to channel, fail-safe, recovery, overcurrent and lock fields.
// - Stored bits become the default configuration after power-up.
// - Store programs only once, guarded by a lock bit set when programming.
// - Command values 0x0 and 0x3 do nothing.
// - Command 0x1 refreshes all 40 bits, then readout shows selected slice.
// - Command 0x2 programs mapped configuration fields plus lock bit.
// - Program command acts only while lock bit is unprogrammed.
// - Active status bit is 1 throughout any refresh or program.
// - Readout returns bits 9:0, 19:10, 29:20 or 39:30 per selector.
// - Fail flag sets on programming supply undervoltage during programming.
// - Reading the fail flag clears it.
// - Revision register at 0x1F: bit 9 zero, bits 8:0 revision code.
// - Undefined reset bits come from diagnostics or manufacturing trim.
// ---------------------------------------------------------------------
package ocs_pkg;

  // -------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------
  localparam logic [4:0] ADDR_CFG0   = 5'h10;
  localparam logic [4:0] ADDR_CFG1   = 5'h11;
  localparam logic [4:0] ADDR_CFG2   = 5'h12;
  localparam logic [4:0] ADDR_CFG3   = 5'h13;
  localparam logic [4:0] ADDR_CTRL   = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h15;
  localparam logic [4:0] ADDR_DATA   = 5'h1E;
  localparam logic [4:0] ADDR_REV    = 5'h1F;

  // Control and status fields
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_BIAS_L  = 4;
  localparam int CTRL_BIAS_H  = 5;
  localparam int STAT_ACTIVE  = 0;
  localparam int STAT_FAIL    = 1;
  localparam int STAT_LOCK    = 2;

  // Store layout
  localparam int STORE_BITS = 40;
  localparam int SLICE_BITS = 10;
  localparam int LOCK_BIT   = 39;

  // Revision code: fixed bits, trimmed bits filled at boot
  localparam logic [9:0] REV_FIXED = 10'h100;

  // Reset values
  localparam logic [38:0] CFG_RESET  = 39'h00_0000_0000;
  localparam logic [9:0]  DATA_RESET = 10'h000;

  // Timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int REFRESH_TIME_NS = 2000;
  localparam int PROG_TIME_NS    = 100000;
  localparam int REFRESH_CYCLES  =
    (REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES     =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OP_NOP  = 2'h0,
    OP_READ = 2'h1,
    OP_ZAP  = 2'h2,
    OP_NOP3 = 2'h3
  } ocs_op_t;

  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_IDLE = 4'h2,
    ST_READ = 4'h4,
    ST_PROG = 4'h8
  } ocs_state_t;

endpackage

/* rtl/ocs_fuse_array.sv */
// Fuse array with timed refresh and program cycles
`timescale 1ns/1ns
module ocs_fuse_array (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           ce,
  input  wire logic                           rst_n,
  // Commands
  input  wire logic                           start_read,
  input  wire logic                           start_prog,
  input  wire logic [ocs_pkg::STORE_BITS-1:0] prog_data,
  input  wire logic                           margin_high,
  input  wire logic                           supply_uv,
  // Results
  output logic                                done,
  output logic                                prog_fail,
  output logic      [ocs_pkg::STORE_BITS-1:0] rdata,
  output logic                                lock
);
  import ocs_pkg::*;

  // Fuses keep their state through reset
  logic [STORE_BITS-1:0] fuse_reg = '0;
  logic [STORE_BITS-1:0] weak_reg = '0;
  logic [16:0]           cnt_reg;
  logic                  run_reg;
  logic                  prog_reg;
  logic                  uv_reg;
  logic                  last;
  logic [STORE_BITS-1:0] margin_view;

  assign last        = run_reg && (cnt_reg == 17'h00000);
  // Weakly blown bits drop out when the high margin is applied
  assign margin_view = margin_high ? (fuse_reg & ~weak_reg) : fuse_reg;
  assign lock        = fuse_reg[LOCK_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg   <= 17'h00000;
      run_reg   <= 1'b0;
      prog_reg  <= 1'b0;
      uv_reg    <= 1'b0;
      done      <= 1'b0;
      prog_fail <= 1'b0;
      rdata     <= '0;
    end else if (ce) begin
      done      <= last;
      prog_fail <= last && prog_reg && uv_reg;
      if (!run_reg && (start_read || start_prog)) begin
        run_reg  <= 1'b1;
        prog_reg <= start_prog;
        uv_reg   <= 1'b0;
        cnt_reg  <= start_prog ? 17'(PROG_CYCLES - 1)
                               : 17'(REFRESH_CYCLES - 1);
      end else if (last) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 17'h00001;
        uv_reg  <= uv_reg || (prog_reg && supply_uv);
      end
      if (last && !prog_reg) begin
        rdata <= margin_view;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && last && prog_reg) begin
      fuse_reg <= fuse_reg | prog_data;
      weak_reg <= weak_reg | (uv_reg ? prog_data : '0);
    end
  end

endmodule

/* rtl/ocs_otp_ctrl.sv */
// Register front end and sequencer of the configuration store
`timescale 1ns/1ns
module ocs_otp_ctrl (
  // Clock, enable and reset
  input  wire logic       CLK_SYS,
  input  wire logic       CE,
  input  wire logic       RST_N,
  // Register access
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [4:0] REG_ADDR,
  input  wire logic [9:0] REG_WDATA,
  output logic      [9:0] REG_RDATA,
  // Pins
  input  wire logic       PROGRAMMING_SUPPLY_UV,
  input  wire logic [3:0] REVISION_TRIM,
  // Status
  output logic            OTP_ACTIVE,
  output logic            OTP_FAIL,
  // Configuration fields
  output logic      [7:0] CH1_VOLTAGE_THRESHOLD,
  output logic      [1:0] CH1_SENSE_THRESHOLD,
  output logic      [7:0] CH2_VOLTAGE_THRESHOLD,
  output logic      [1:0] CH2_SENSE_THRESHOLD,
  output logic      [4:0] CH1_OFF_TIME,
  output logic      [4:0] CH2_OFF_TIME,
  output logic            CH1_ENABLE,
  output logic            CH2_ENABLE,
  output logic      [2:0] FAILSAFE_SETTING,
  output logic            CH1_THERMAL_AUTO_RECOVER,
  output logic            CH2_THERMAL_AUTO_RECOVER,
  output logic      [1:0] OVERCURRENT_CMP_THRESHOLD
);

  import ocs_pkg::*;

  ocs_state_t      state_reg;
  ocs_state_t      state_next;
  logic [38:0]     cfg_reg;
  logic [39:0]     image_reg;
  logic [1:0]      op_reg;
  logic [1:0]      sel_reg;
  logic            bias_l_reg;
  logic            bias_h_reg;
  logic [9:0]      rev_reg;
  logic [9:0]      rdata_next;
  logic            uv_s1;
  logic            uv_s2;
  logic [3:0]      trim_s1;
  logic [3:0]      trim_s2;
  logic            fuse_done;
  logic            fuse_fail;
  logic            fuse_lock;
  logic [39:0]     fuse_rdata;
  logic            start_read;
  logic            start_prog;
  logic            idle;
  logic            wr_ctrl;
  logic            rd_status;
  logic [9:0]      data_view;
  logic [9:0]      status_view;

  function automatic logic [9:0] slice_of(input logic [39:0] v,
                                          input logic [1:0]  s);
    slice_of = v[s*SLICE_BITS +: SLICE_BITS];
  endfunction

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  // -------------------------------------------------------------------
  // Decode and sequencing
  // -------------------------------------------------------------------
  assign idle        = (state_reg == ST_IDLE);
  assign wr_ctrl     = REG_WR && hit(REG_ADDR, ADDR_CTRL);
  assign rd_status   = REG_RD && hit(REG_ADDR, ADDR_STATUS);
  assign start_read  = (state_reg == ST_BOOT && !OTP_ACTIVE)
                    || (idle && op_reg == OP_READ);
  assign start_prog  = idle && op_reg == OP_ZAP && !fuse_lock;
  assign data_view   = slice_of(image_reg, sel_reg);
  assign status_view = {7'h00, fuse_lock, OTP_FAIL, OTP_ACTIVE};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_BOOT: if (fuse_done) state_next = ST_IDLE;
      ST_IDLE: begin
        if (start_read) state_next = ST_READ;
        else if (start_prog) state_next = ST_PROG;
      end
      ST_READ: if (fuse_done) state_next = ST_IDLE;
      ST_PROG: if (fuse_done) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    rdata_next = 10'h000;
    if (hit(REG_ADDR, ADDR_CFG0)) rdata_next = cfg_reg[9:0];
    if (hit(REG_ADDR, ADDR_CFG1)) rdata_next = cfg_reg[19:10];
    if (hit(REG_ADDR, ADDR_CFG2)) rdata_next = cfg_reg[29:20];
    if (hit(REG_ADDR, ADDR_CFG3)) rdata_next = {1'b0, cfg_reg[38:30]};
    if (hit(REG_ADDR, ADDR_CTRL))
      rdata_next = {4'h0, bias_h_reg, bias_l_reg, sel_reg, op_reg};
    if (hit(REG_ADDR, ADDR_STATUS)) rdata_next = status_view;
    if (hit(REG_ADDR, ADDR_DATA))   rdata_next = data_view;
    if (hit(REG_ADDR, ADDR_REV))    rdata_next = rev_reg;
  end

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      uv_s1   <= 1'b0;
      uv_s2   <= 1'b0;
      trim_s1 <= 4'h0;
      trim_s2 <= 4'h0;
    end else if (CE) begin
      uv_s1   <= PROGRAMMING_SUPPLY_UV;
      uv_s2   <= uv_s1;
      trim_s1 <= REVISION_TRIM;
      trim_s2 <= trim_s1;
    end
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_reg  <= ST_BOOT;
      OTP_ACTIVE <= 1'b0;
      op_reg     <= OP_NOP;
      sel_reg    <= 2'h0;
      bias_l_reg <= 1'b0;
      bias_h_reg <= 1'b0;
    end else if (CE) begin
      state_reg  <= state_next;
      OTP_ACTIVE <= (state_next != ST_IDLE);
      if (wr_ctrl) begin
        sel_reg    <= REG_WDATA[CTRL_SEL_LSB +: 2];
        bias_l_reg <= REG_WDATA[CTRL_BIAS_L];
        bias_h_reg <= REG_WDATA[CTRL_BIAS_H];
      end
      if (wr_ctrl && idle && op_reg == OP_NOP)
        op_reg <= REG_WDATA[CTRL_OP_LSB +: 2];
      else if (idle && !start_read && !start_prog)
        op_reg <= OP_NOP;
      else if (fuse_done)
        op_reg <= OP_NOP;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cfg_reg   <= CFG_RESET;
      image_reg <= {1'b0, CFG_RESET};
      rev_reg   <= REV_FIXED;
      OTP_FAIL  <= 1'b0;
      REG_RDATA <= DATA_RESET;
    end else if (CE) begin
      if (state_reg == ST_BOOT && fuse_done) begin
        cfg_reg <= fuse_rdata[38:0];
        rev_reg <= REV_FIXED | {5'h00, trim_s2[3:2], 1'b0, trim_s2[1:0]};
      end else if (REG_WR) begin
        if (hit(REG_ADDR, ADDR_CFG0)) cfg_reg[9:0]   <= REG_WDATA;
        if (hit(REG_ADDR, ADDR_CFG1)) cfg_reg[19:10] <= REG_WDATA;
        if (hit(REG_ADDR, ADDR_CFG2)) cfg_reg[29:20] <= REG_WDATA;
        if (hit(REG_ADDR, ADDR_CFG3)) cfg_reg[38:30] <= REG_WDATA[8:0];
      end
      if (state_reg != ST_PROG && fuse_done)
        image_reg <= fuse_rdata;
      OTP_FAIL  <= fuse_fail || (OTP_FAIL && !rd_status);
      if (REG_RD)
        REG_RDATA <= rdata_next;
    end
  end

  // Mapped configuration fields
  assign CH1_VOLTAGE_THRESHOLD     = cfg_reg[7:0];
  assign CH1_SENSE_THRESHOLD       = cfg_reg[9:8];
  assign CH2_VOLTAGE_THRESHOLD     = cfg_reg[17:10];
  assign CH2_SENSE_THRESHOLD       = cfg_reg[19:18];
  assign CH1_OFF_TIME              = cfg_reg[24:20];
  assign CH2_OFF_TIME              = cfg_reg[29:25];
  assign CH1_ENABLE                = cfg_reg[30];
  assign CH2_ENABLE                = cfg_reg[31];
  assign FAILSAFE_SETTING          = cfg_reg[34:32];
  assign CH1_THERMAL_AUTO_RECOVER  = cfg_reg[35];
  assign CH2_THERMAL_AUTO_RECOVER  = cfg_reg[36];
  assign OVERCURRENT_CMP_THRESHOLD = cfg_reg[38:37];

  ocs_fuse_array u_fuse (
    .clk         (CLK_SYS),
    .ce          (CE),
    .rst_n       (RST_N),
    .start_read  (start_read),
    .start_prog  (start_prog),
    .prog_data   ({1'b1, cfg_reg}),
    .margin_high (bias_h_reg),
    .supply_uv   (uv_s2),
    .done        (fuse_done),
    .prog_fail   (fuse_fail),
    .rdata       (fuse_rdata),
    .lock        (fuse_lock)
  );

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_busy_on_read: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && idle && op_reg == OP_READ |=> OTP_ACTIVE && state_reg == ST_READ)
    else $error("active flag not raised on refresh");

  a_nop_stays_idle: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && idle && (op_reg == OP_NOP || op_reg == OP_NOP3) |=> idle)
    else $error("no-operation command started an operation");

  a_zap_when_locked: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && idle && op_reg == OP_ZAP && fuse_lock |=> idle && !OTP_ACTIVE)
    else $error("program started while locked");

  a_fail_read_clear: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && rd_status && !fuse_fail |=> !OTP_FAIL)
    else $error("fail flag not cleared by read");

  a_fail_set_wins: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && fuse_fail |=> OTP_FAIL)
    else $error("fail flag not set");

  a_lock_after_zap: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && state_reg == ST_PROG && fuse_done |=> fuse_lock && idle)
    else $error("lock not set by programming");

  a_busy_cmd_ignored: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && !idle && wr_ctrl && !fuse_done |=> op_reg == $past(op_reg))
    else $error("command accepted while busy");

  a_refresh_image: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && state_reg == ST_READ && fuse_done |=> image_reg == $past(fuse_rdata))
    else $error("refresh did not update readout image");

  a_readout_slice: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && REG_RD && hit(REG_ADDR, ADDR_DATA)
    |=> REG_RDATA == slice_of($past(image_reg), $past(sel_reg)))
    else $error("readout slice wrong");

  a_revision_bits: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && REG_RD && hit(REG_ADDR, ADDR_REV)
    |=> REG_RDATA[9] == 1'b0 && REG_RDATA[8:5] == 4'h8 && !REG_RDATA[2])
    else $error("revision register fixed bits wrong");

  a_boot_load: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && state_reg == ST_BOOT && fuse_done
    |=> cfg_reg == $past(fuse_rdata[38:0]))
    else $error("boot did not load configuration");

endmodule

/* dv/ocs_host.sv */
// Register-bus host model for the configuration store controller
`timescale 1ns/1ns
module ocs_host (
  // Clock
  input  wire logic       clk,
  // Register bus
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [9:0] reg_wdata,
  input  wire logic [9:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 10'h000;
  end

  // One-cycle write strobe, data scrambled once released
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Read answer is registered on the taking edge and sampled one edge later
  task automatic rd(input logic [4:0] a, output logic [9:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the configuration store controller
`timescale 1ns/1ns
module testbench;
  import ocs_pkg::*;
  localparam logic [39:0] IMG = {1'b1, 9'h0F0, 10'h3C3, 10'h15A, 10'h2A5};
  logic        clk_sys = 1'b0;
  logic        ce      = 1'b1;
  logic        rst_n   = 1'b0;
  logic        uv      = 1'b0;
  logic [3:0]  trim    = 4'hB;
  wire         wr_s;
  wire         rd_s;
  wire  [4:0]  addr;
  wire  [9:0]  wdata;
  wire  [9:0]  rdata;
  wire         otp_active;
  wire         otp_fail;
  wire  [38:0] cfg_out;
  int          errors  = 0;
  int          checked = 0;

  initial forever #50 clk_sys = ~clk_sys;

  ocs_host host (.clk(clk_sys), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));

  ocs_otp_ctrl dut (
    .CLK_SYS(clk_sys), .CE(ce), .RST_N(rst_n), .REG_WR(wr_s),
    .REG_RD(rd_s), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .PROGRAMMING_SUPPLY_UV(uv), .REVISION_TRIM(trim),
    .OTP_ACTIVE(otp_active), .OTP_FAIL(otp_fail),
    .CH1_VOLTAGE_THRESHOLD(cfg_out[7:0]), .CH1_SENSE_THRESHOLD(cfg_out[9:8]),
    .CH2_VOLTAGE_THRESHOLD(cfg_out[17:10]),
    .CH2_SENSE_THRESHOLD(cfg_out[19:18]), .CH1_OFF_TIME(cfg_out[24:20]),
    .CH2_OFF_TIME(cfg_out[29:25]), .CH1_ENABLE(cfg_out[30]),
    .CH2_ENABLE(cfg_out[31]), .FAILSAFE_SETTING(cfg_out[34:32]),
    .CH1_THERMAL_AUTO_RECOVER(cfg_out[35]),
    .CH2_THERMAL_AUTO_RECOVER(cfg_out[36]),
    .OVERCURRENT_CMP_THRESHOLD(cfg_out[38:37]));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string s, input logic [39:0] e,
                     input logic [39:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chk_len(input string s, input int n, input int lo,
                         input int hi);
    checked++;
    if (n < lo || n > hi) begin
      errors++;
      $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, n);
    end
  endtask

  task finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Counts busy cycles until busy falls again
  task automatic wait_done(output int n);
    n = 0;
    for (int i = 0; i < 1100; i++) begin
      @(posedge clk_sys);
      #1;
      if (otp_active === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    if (otp_active !== 1'b0) begin
      errors++;
      $display("Error busy_timeout expected 0 seen %b", otp_active);
      finish_test();
    end
  endtask

  task automatic run_op(input logic [9:0] c, output int n);
    host.wr(ADDR_CTRL, c);
    wait_done(n);
  endtask

  task automatic do_reset;
    int n;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_done(n);
    chk_len("boot_len", n, REFRESH_CYCLES, REFRESH_CYCLES + 3);
  endtask

  // Refresh with margin m, then read all four slices
  task automatic check_image(input logic [1:0] m, input logic [39:0] exp,
                             input logic hi);
    int n;
    logic [9:0] d;
    run_op({4'h0, m, 4'h1}, n);
    chk_len("refresh_len", n, REFRESH_CYCLES, REFRESH_CYCLES + 3);
    for (int k = 0; k < 4; k++) begin
      host.wr(ADDR_CTRL, {4'h0, m, 2'(k), 2'h0});
      host.rd(ADDR_DATA, d);
      if (hi)
        chk("slice_hi", 40'h0, 40'(d));
      else
        chk("slice", 40'(exp[k*10 +: 10]), 40'(d));
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_boot;
    logic [9:0] d;
    host.rd(ADDR_REV, d);
    chk("revision", 40'h113, 40'(d));
    host.rd(5'h00, d);
    chk("unmapped", 40'h0, 40'(d));
    host.rd(ADDR_STATUS, d);
    chk("status_boot", 40'h0, 40'(d));
    chk("cfg_zero", 40'h0, {1'b0, cfg_out});
  endtask

  task automatic t_nop;
    int n;
    logic [9:0] d;
    for (int k = 0; k < 2; k++) begin
      run_op(10'(k * 3), n);
      chk_len("nop_len", n, 0, 0);
      host.rd(ADDR_CTRL, d);
      chk("nop_op", 40'h0, 40'(d[1:0]));
    end
    check_image(2'b00, 40'h0, 1'b0);
  endtask

  task automatic t_prog;
    int n;
    logic [9:0] d;
    for (int k = 0; k < 3; k++)
      host.wr(ADDR_CFG0 + 5'(k), IMG[k*10 +: 10]);
    host.wr(ADDR_CFG3, {1'b0, IMG[38:30]});
    uv <= 1'b1;
    host.wr(ADDR_CTRL, 10'h002);
    repeat (5) @(posedge clk_sys);
    host.wr(ADDR_CTRL, 10'h001);
    wait_done(n);
    chk_len("prog_len", n, PROG_CYCLES - 10, PROG_CYCLES);
    chk("fail_pin", 40'h1, 40'(otp_fail));
    @(posedge clk_sys);
    uv <= 1'b0;
    host.rd(ADDR_STATUS, d);
    chk("fail_set", 40'h1, 40'(d[1]));
    host.rd(ADDR_STATUS, d);
    chk("fail_clear", 40'h0, 40'(d[1]));
    host.rd(ADDR_CTRL, d);
    chk("prog_op", 40'h0, 40'(d[1:0]));
  endtask

  task automatic t_verify;
    logic [9:0] d;
    check_image(2'b01, IMG, 1'b0);
    check_image(2'b10, IMG, 1'b1);
    host.rd(ADDR_STATUS, d);
    chk("lock", 40'h1, 40'(d[2]));
  endtask

  task automatic t_relock;
    int n;
    host.wr(ADDR_CFG0, 10'h3FF);
    run_op(10'h002, n);
    chk_len("relock_len", n, 0, 0);
    check_image(2'b01, IMG, 1'b0);
  endtask

  task automatic t_reboot;
    do_reset();
    chk("cfg_boot", {1'b0, IMG[38:0]}, {1'b0, cfg_out});
  endtask

  // ---------------------------------------------------------------
  // Main
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    t_boot();
    t_nop();
    t_prog();
    t_verify();
    t_relock();
    t_reboot();
    finish_test();
  end
endmodule
